// file: core/clk_ctrl_pkg.sv
// Package: register map, field layout, reset values and states of the clock control block
package clk_ctrl_pkg;

   // Register indices; the byte address on the bus is four times the index
   localparam logic [7:0] OSC_TRIM_IDX = 8'h31;
   localparam logic [7:0] CLK_DIV_IDX = 8'h30;
   localparam logic [7:0] MCU_CTRL_IDX = 8'h32;
   localparam logic [7:0] STATUS_IDX = 8'h33;
   localparam logic [11:0] OSC_TRIM_ADDR = {2'b00, OSC_TRIM_IDX, 2'b00};
   localparam logic [11:0] CLK_DIV_ADDR = {2'b00, CLK_DIV_IDX, 2'b00};
   localparam logic [11:0] MCU_CTRL_ADDR = {2'b00, MCU_CTRL_IDX, 2'b00};
   localparam logic [11:0] STATUS_ADDR = {2'b00, STATUS_IDX, 2'b00};

   // Divider register layout
   localparam int UNLOCK_BIT = 7;
   localparam int DIV_SEL_MSB = 3;
   localparam logic [3:0] DIV_SEL_RST_PLAIN = 4'h0;
   localparam logic [3:0] DIV_SEL_RST_DIV8 = 4'h3;
   localparam logic [3:0] DIV_SEL_MAX = 4'h8;

   // Unlock window length in pclk cycles
   localparam logic [2:0] UNLOCK_WINDOW_CYC = 3'h4;

   // Sleep control register layout
   localparam int SLEEP_KIND_LSB = 0;
   localparam int SLEEP_ARM_BIT = 2;

   // Reset values: trim held until the strap load in the first cycle after reset; read data
   localparam logic [7:0] OSC_TRIM_RST = 8'h00;
   localparam logic [31:0] RDATA_RST = 32'h0000_0000;

   typedef enum logic [1:0] {
      SLEEP_IDLE = 2'b00,
      SLEEP_ADC_NR = 2'b01,
      SLEEP_PDOWN = 2'b10,
      SLEEP_STANDBY = 2'b11
   } sleep_kind_t;

   typedef enum logic [1:0] {
      ST_RUN = 2'b00,
      ST_SLEEP = 2'b01
   } pm_state_t;

endpackage

// file: core/sysclk_divider.sv
// Glitch-free power-of-two system clock enable divider
`timescale 1ns/1ps
module sysclk_divider (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Requested division code
   input wire logic [3:0] div_select,
   // Divided enable and code in force
   output logic sys_tick,
   output logic [3:0] active_sel
);

   logic [7:0] cnt_reg;
   logic [7:0] cnt_next;
   logic [3:0] active_sel_reg;
   logic [3:0] active_sel_next;
   logic tick_reg;
   wire logic [3:0] eff_sel;
   wire logic [8:0] mask_wide;
   wire logic [7:0] mask;
   wire logic period_end;

   // Reserved codes run at the slowest legal rate
   assign eff_sel = (div_select > clk_ctrl_pkg::DIV_SEL_MAX) ? clk_ctrl_pkg::DIV_SEL_MAX : div_select;
   assign mask_wide = (9'h001 << active_sel_reg) - 9'h001;
   assign mask = mask_wide[7:0];
   assign period_end = ((cnt_reg & mask) == mask);

   // A new code only lands at the end of an old period, so no short pulse appears
   assign active_sel_next = period_end ? eff_sel : active_sel_reg;
   assign cnt_next = period_end ? 8'h00 : cnt_reg + 8'h01;

   // Counter, code and tick
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_reg <= 8'h00;
         active_sel_reg <= 4'h0;
         tick_reg <= 1'b0;
      end else begin
         cnt_reg <= cnt_next;
         active_sel_reg <= active_sel_next;
         tick_reg <= period_end;
      end
   end

   assign sys_tick = tick_reg;
   assign active_sel = active_sel_reg;

   property p_switch_at_period_end;
      @(posedge pclk) disable iff (!presetn)
      (active_sel_reg != $past(active_sel_reg)) |-> $past(period_end);
   endproperty
   a_switch_at_period_end: assert property (p_switch_at_period_end) else $error("divider code changed mid-period");

endmodule // sysclk_divider

// file: core/clk_trim_prescale_sleep.sv
// Clock control: oscillator trim, unlocked system divider and sleep clock gating behind APB
`timescale 1ns/1ps

// Overview of operation
// - Each reset loads the trim register with the factory calibration byte.
// - Software may write the trim register anytime; the new value drives out at once.
// - Top trim bit picks low or high range; ranges overlap.
// - Lower seven trim bits tune frequency upward from 0x00 to 0x7F.
// - Unlock bit sets only when all other divider bits are written zero.
// - Unlock clears four cycles after setting, or at a select write.
// - Rewriting unlock inside the window neither restarts it nor clears it.
// - Divider bits 6 to 4 ignore writes and read zero.
// - Select changes only by unlock write then select write within four cycles.
// - Reset select is 0000, or 0011 when the divide-by-eight fuse is set.
// - After unlock any select value is accepted regardless of the fuse.
// - Division factor is two to the code, codes 0 to 8; higher reserved.
// - The divided tick paces CPU and all synchronous peripherals alike.
// - Idle stops CPU and flash; I/O, ADC, oscillator run; any interrupt wakes.
// - In ADC noise reduction and power-down, line0 wakes only in its level form.
// - Power-down stops all clocks and oscillator; level, pin change, watchdog wake.
// - Sleep kind 00 idle, 01 ADC noise reduction, 10 power-down, 11 standby.
// - Sleep starts only if the arm bit is set when sleep executes.
// - Divider changes are glitch-free, taking effect after one old and new period; here the new code lands at the end of the current old period.
module clk_trim_prescale_sleep (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Straps sampled after reset
   input wire logic [7:0] cal_byte,
   input wire logic div8_fuse_default,
   // Processor sleep request and wake sources
   input wire logic sleep_exec,
   input wire logic ext_irq_line0,
   input wire logic ext_irq_edge,
   input wire logic pin_change_irq,
   input wire logic wdt_irq,
   input wire logic self_prog_store_ready,
   input wire logic adc_irq,
   input wire logic other_io_irq,
   // Oscillator trim
   output logic trim_range_sel,
   output logic [6:0] trim_fine,
   // Clock domain enables and divided tick
   output logic sys_tick,
   output logic cpu_clk_en,
   output logic flash_clk_en,
   output logic io_clk_en,
   output logic adc_clk_en,
   output logic osc_en,
   output logic wake_pulse
);

   logic init_done_reg;
   logic [7:0] osc_trim_reg;
   logic [7:0] osc_trim_next;
   logic [3:0] div_sel_reg;
   logic [3:0] div_sel_next;
   logic unlock_reg;
   logic unlock_next;
   logic [2:0] unlock_cnt_reg;
   logic [2:0] unlock_cnt_next;
   logic [1:0] sleep_kind_sel;
   logic sleep_arm;
   clk_ctrl_pkg::sleep_kind_t act_kind_reg;
   clk_ctrl_pkg::pm_state_t state_reg;
   clk_ctrl_pkg::pm_state_t state_next;
   logic cpu_en_reg;
   logic flash_en_reg;
   logic io_en_reg;
   logic adc_en_reg;
   logic osc_en_reg;
   logic wake_reg;
   logic [31:0] prdata_reg;
   logic pready_reg;
   logic pslverr_reg;
   wire logic [3:0] active_sel;
   wire logic div_tick;

   // Bus decode; misaligned addresses count as unmapped
   wire logic setup_ph = psel && !penable;
   wire logic access_ph = psel && penable && pready_reg;
   wire logic wr_en = access_ph && pwrite;
   wire logic hit_trim = (paddr == clk_ctrl_pkg::OSC_TRIM_ADDR);
   wire logic hit_div = (paddr == clk_ctrl_pkg::CLK_DIV_ADDR);
   wire logic hit_mcu = (paddr == clk_ctrl_pkg::MCU_CTRL_ADDR);
   wire logic hit_stat = (paddr == clk_ctrl_pkg::STATUS_ADDR);
   wire logic mapped = hit_trim || hit_div || hit_mcu || hit_stat;
   wire logic wr_trim = wr_en && hit_trim;
   wire logic wr_div = wr_en && hit_div;
   wire logic wr_mcu = wr_en && hit_mcu;

   // Divider write classes
   wire logic unlock_req = wr_div && pwdata[clk_ctrl_pkg::UNLOCK_BIT]
                           && (pwdata[clk_ctrl_pkg::UNLOCK_BIT-1:0] == 7'h00);
   wire logic sel_write = wr_div && !pwdata[clk_ctrl_pkg::UNLOCK_BIT];
   wire logic apply_sel = sel_write && unlock_reg;
   wire logic window_end = unlock_reg && (unlock_cnt_reg == clk_ctrl_pkg::UNLOCK_WINDOW_CYC - 3'h1);

   // Read data; reserved divider bits are hard zero
   wire logic [31:0] rd_trim = {24'h00_0000, osc_trim_reg};
   wire logic [31:0] rd_div = {24'h00_0000, unlock_reg, 3'b000, div_sel_reg};
   wire logic [31:0] rd_mcu = {29'h0000_0000, sleep_arm, sleep_kind_sel};
   wire logic [31:0] rd_stat = {20'h0_0000, osc_en_reg, adc_en_reg, io_en_reg, flash_en_reg, cpu_en_reg,
                               (state_reg == clk_ctrl_pkg::ST_SLEEP), act_kind_reg, active_sel};
   wire logic [31:0] rdata_w = hit_trim ? rd_trim :
                               hit_div ? rd_div :
                               hit_mcu ? rd_mcu :
                               hit_stat ? rd_stat : clk_ctrl_pkg::RDATA_RST;

   // Trim: strap copy once after reset, then software at will
   assign osc_trim_next = !init_done_reg ? cal_byte :
                          wr_trim ? pwdata[7:0] : osc_trim_reg;

   // Select: fuse default once after reset, then only through the unlock sequence
   assign div_sel_next = !init_done_reg ? (div8_fuse_default ? clk_ctrl_pkg::DIV_SEL_RST_DIV8
                                                            : clk_ctrl_pkg::DIV_SEL_RST_PLAIN) :
                         apply_sel ? pwdata[clk_ctrl_pkg::DIV_SEL_MSB:0] : div_sel_reg;

   // Unlock: a repeat request while open is ignored so the window is not stretched
   assign unlock_next = sel_write ? 1'b0 :
                        (unlock_req && !unlock_reg) ? 1'b1 :
                        window_end ? 1'b0 : unlock_reg;
   assign unlock_cnt_next = (unlock_req && !unlock_reg) ? 3'h0 :
                            unlock_reg ? unlock_cnt_reg + 3'h1 : 3'h0;

   // Wake sources allowed in each sleep kind; edge form of line0 wakes only from idle
   wire logic any_irq = ext_irq_line0 || ext_irq_edge || pin_change_irq || wdt_irq
                        || self_prog_store_ready || adc_irq || other_io_irq;
   wire logic adc_nr_wake = ext_irq_line0 || pin_change_irq || wdt_irq
                            || self_prog_store_ready || adc_irq;
   wire logic pdown_wake = ext_irq_line0 || pin_change_irq || wdt_irq;
   wire logic wake_hit = (act_kind_reg == clk_ctrl_pkg::SLEEP_IDLE) ? any_irq :
                         (act_kind_reg == clk_ctrl_pkg::SLEEP_ADC_NR) ? adc_nr_wake : pdown_wake;
   wire logic enter_sleep = sleep_exec && sleep_arm;

   // Power state sequencing
   always_comb begin
      case (state_reg)
         clk_ctrl_pkg::ST_RUN: begin
            state_next = enter_sleep ? clk_ctrl_pkg::ST_SLEEP : clk_ctrl_pkg::ST_RUN;
         end
         clk_ctrl_pkg::ST_SLEEP: begin
            state_next = wake_hit ? clk_ctrl_pkg::ST_RUN : clk_ctrl_pkg::ST_SLEEP;
         end
         default: begin
            state_next = clk_ctrl_pkg::ST_RUN;
         end
      endcase
   end

   // Kind in force for the coming state; taken from the control field at entry
   wire clk_ctrl_pkg::sleep_kind_t kind_next = (state_reg == clk_ctrl_pkg::ST_RUN && enter_sleep) ?
                                               clk_ctrl_pkg::sleep_kind_t'(sleep_kind_sel) : act_kind_reg;
   wire logic sleeping_next = (state_next == clk_ctrl_pkg::ST_SLEEP);

   // Domain gates follow the next state so they line up with the state register
   wire logic cpu_en_next = !sleeping_next;
   wire logic io_en_next = !sleeping_next || (kind_next == clk_ctrl_pkg::SLEEP_IDLE);
   wire logic adc_en_next = !sleeping_next || (kind_next == clk_ctrl_pkg::SLEEP_IDLE)
                            || (kind_next == clk_ctrl_pkg::SLEEP_ADC_NR);
   wire logic osc_en_next = !sleeping_next || (kind_next != clk_ctrl_pkg::SLEEP_PDOWN);

   // Strap capture flag: async reset may only load constants, so straps load after release
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         init_done_reg <= 1'b0;
      end else begin
         init_done_reg <= 1'b1;
      end
   end

   // Trim, divider and unlock registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         osc_trim_reg <= clk_ctrl_pkg::OSC_TRIM_RST;
         div_sel_reg <= clk_ctrl_pkg::DIV_SEL_RST_PLAIN;
         unlock_reg <= 1'b0;
         unlock_cnt_reg <= 3'h0;
      end else begin
         osc_trim_reg <= osc_trim_next;
         div_sel_reg <= div_sel_next;
         unlock_reg <= unlock_next;
         unlock_cnt_reg <= unlock_cnt_next;
      end
   end

   // Sleep control fields
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sleep_kind_sel <= 2'b00;
         sleep_arm <= 1'b0;
      end else if (wr_mcu) begin
         sleep_kind_sel <= pwdata[clk_ctrl_pkg::SLEEP_KIND_LSB +: 2];
         sleep_arm <= pwdata[clk_ctrl_pkg::SLEEP_ARM_BIT];
      end
   end

   // Power state and gates
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg <= clk_ctrl_pkg::ST_RUN;
         act_kind_reg <= clk_ctrl_pkg::SLEEP_IDLE;
         cpu_en_reg <= 1'b1;
         flash_en_reg <= 1'b1;
         io_en_reg <= 1'b1;
         adc_en_reg <= 1'b1;
         osc_en_reg <= 1'b1;
         wake_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         act_kind_reg <= kind_next;
         cpu_en_reg <= cpu_en_next;
         flash_en_reg <= cpu_en_next;
         io_en_reg <= io_en_next;
         adc_en_reg <= adc_en_next;
         osc_en_reg <= osc_en_next;
         wake_reg <= (state_reg == clk_ctrl_pkg::ST_SLEEP) && wake_hit;
      end
   end

   // Bus answer: data captured in setup, zero wait states, error for unmapped addresses
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_reg <= clk_ctrl_pkg::RDATA_RST;
         pready_reg <= 1'b0;
         pslverr_reg <= 1'b0;
      end else begin
         pready_reg <= 1'b1;
         if (setup_ph) begin
            prdata_reg <= pwrite ? clk_ctrl_pkg::RDATA_RST : rdata_w;
            pslverr_reg <= !mapped;
         end else if (access_ph) begin
            pslverr_reg <= 1'b0;
         end
      end
   end

   // One divided tick paces every synchronous consumer
   sysclk_divider sysclk_divider_inst (
      .pclk(pclk),
      .presetn(presetn),
      .div_select(div_sel_reg),
      .sys_tick(div_tick),
      .active_sel(active_sel)
   );

   assign prdata = prdata_reg;
   assign pready = pready_reg;
   assign pslverr = pslverr_reg;
   assign trim_range_sel = osc_trim_reg[7];
   assign trim_fine = osc_trim_reg[6:0];
   assign sys_tick = div_tick;
   assign cpu_clk_en = cpu_en_reg;
   assign flash_clk_en = flash_en_reg;
   assign io_clk_en = io_en_reg;
   assign adc_clk_en = adc_en_reg;
   assign osc_en = osc_en_reg;
   assign wake_pulse = wake_reg;

   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   property p_trim_load;
      $rose(init_done_reg) |-> (osc_trim_reg == $past(cal_byte));
   endproperty
   a_trim_load: assert property (p_trim_load) else $error("trim not loaded from calibration");

   property p_trim_write;
      wr_trim |=> ({trim_range_sel, trim_fine} == $past(pwdata[7:0]));
   endproperty
   a_trim_write: assert property (p_trim_write) else $error("trim write not applied");

   property p_unlock_cause;
      $rose(unlock_reg) |-> $past(unlock_req);
   endproperty
   a_unlock_cause: assert property (p_unlock_cause) else $error("unlock set without clean write");

   property p_unlock_window;
      ($rose(unlock_reg) && !$past(sel_write)) ##0 (!sel_write)[*4] |=> !unlock_reg;
   endproperty
   a_unlock_window: assert property (p_unlock_window) else $error("unlock outlived four cycles");

   property p_unlock_rewrite;
      (unlock_reg && unlock_req && !window_end) |=> unlock_reg && (unlock_cnt_reg == $past(unlock_cnt_reg) + 3'h1);
   endproperty
   a_unlock_rewrite: assert property (p_unlock_rewrite) else $error("rewrite disturbed unlock");

   property p_reserved_zero;
      (setup_ph && !pwrite && hit_div) |=> (prdata_reg[6:4] == 3'b000);
   endproperty
   a_reserved_zero: assert property (p_reserved_zero) else $error("reserved divider bits nonzero");

   property p_sel_guarded;
      ($past(init_done_reg) && (div_sel_reg != $past(div_sel_reg))) |-> $past(apply_sel);
   endproperty
   a_sel_guarded: assert property (p_sel_guarded) else $error("select changed without unlock");

   property p_fuse_default;
      $rose(init_done_reg) |-> (div_sel_reg == ($past(div8_fuse_default) ? 4'h3 : 4'h0));
   endproperty
   a_fuse_default: assert property (p_fuse_default) else $error("wrong divider reset value");

   property p_any_value;
      apply_sel |=> (div_sel_reg == $past(pwdata[3:0]));
   endproperty
   a_any_value: assert property (p_any_value) else $error("unlocked select not taken");

   property p_idle_gates;
      (state_reg == clk_ctrl_pkg::ST_SLEEP && act_kind_reg == clk_ctrl_pkg::SLEEP_IDLE)
         |-> (!cpu_clk_en && !flash_clk_en && io_clk_en && adc_clk_en && osc_en);
   endproperty
   a_idle_gates: assert property (p_idle_gates) else $error("idle gating wrong");

   property p_adc_nr_edge;
      (state_reg == clk_ctrl_pkg::ST_SLEEP && act_kind_reg == clk_ctrl_pkg::SLEEP_ADC_NR && !adc_nr_wake)
         |=> (state_reg == clk_ctrl_pkg::ST_SLEEP) && !cpu_clk_en && !io_clk_en && adc_clk_en && osc_en;
   endproperty
   a_adc_nr_edge: assert property (p_adc_nr_edge) else $error("noise reduction woke or gated wrongly");

   property p_pdown;
      (state_reg == clk_ctrl_pkg::ST_SLEEP && act_kind_reg == clk_ctrl_pkg::SLEEP_PDOWN && !pdown_wake)
         |=> (state_reg == clk_ctrl_pkg::ST_SLEEP) && !osc_en && !adc_clk_en && !io_clk_en;
   endproperty
   a_pdown: assert property (p_pdown) else $error("power-down woke or clock left running");

   property p_arm_needed;
      $rose(state_reg == clk_ctrl_pkg::ST_SLEEP) |-> $past(sleep_exec && sleep_arm);
   endproperty
   a_arm_needed: assert property (p_arm_needed) else $error("sleep entered without arm");

   property p_kind_map;
      $rose(state_reg == clk_ctrl_pkg::ST_SLEEP) |-> (act_kind_reg == $past(sleep_kind_sel));
   endproperty
   a_kind_map: assert property (p_kind_map) else $error("sleep kind not taken from field");

   c_div_change: cover property (unlock_req ##[1:3] apply_sel);
   c_pdown_wake: cover property ((state_reg == clk_ctrl_pkg::ST_SLEEP && act_kind_reg == clk_ctrl_pkg::SLEEP_PDOWN)
                                 ##1 wake_pulse);
   c_idle_sleep: cover property (enter_sleep && sleep_kind_sel == 2'b00);
   c_unlock_timeout: cover property ($rose(unlock_reg) ##4 !unlock_reg);

endmodule // clk_trim_prescale_sleep

// file: test/clk_trim_prescale_sleep_tb.sv
// Self-checking bench for the clock trim, prescaler and sleep control block
`timescale 1ns/1ps
module clk_trim_prescale_sleep_tb;
   logic pclk, presetn, psel, penable, pwrite, div8_fuse_default, sleep_exec;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [7:0] cal_byte, t;
   logic [6:0] irq_v, trim_fine;
   logic pready, pslverr, trim_range_sel, sys_tick, wake_pulse;
   logic cpu_clk_en, flash_clk_en, io_clk_en, adc_clk_en, osc_en;
   logic [32:0] exp_v;
   logic [32:0] exp_q[$];
   int err_count = 0;
   int total_checks = 0;
   int n, r;
   wire logic [4:0] en_v = {osc_en, adc_clk_en, io_clk_en, flash_clk_en, cpu_clk_en};
   // Per sleep kind: enables in force, sources that must not wake, sources that wake
   logic [4:0] en_tab [4] = '{5'b11100, 5'b11000, 5'b00000, 5'b10000};
   logic [6:0] no_tab [4] = '{7'h00, 7'b0100001, 7'b0100111, 7'b0100111};
   logic [6:0] wake_tab [4] = '{7'b0100001, 7'b0000110, 7'b0001000, 7'b1010000};

   clk_trim_prescale_sleep clk_trim_prescale_sleep_inst (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .cal_byte(cal_byte), .div8_fuse_default(div8_fuse_default), .sleep_exec(sleep_exec),
      .ext_irq_line0(irq_v[6]), .ext_irq_edge(irq_v[5]), .pin_change_irq(irq_v[4]),
      .wdt_irq(irq_v[3]), .self_prog_store_ready(irq_v[2]), .adc_irq(irq_v[1]),
      .other_io_irq(irq_v[0]), .trim_range_sel(trim_range_sel), .trim_fine(trim_fine),
      .sys_tick(sys_tick), .cpu_clk_en(cpu_clk_en), .flash_clk_en(flash_clk_en),
      .io_clk_en(io_clk_en), .adc_clk_en(adc_clk_en), .osc_en(osc_en), .wake_pulse(wake_pulse));

   // Free-running 250 MHz clock
   initial begin
      pclk = 1'b0;
      forever #2 pclk = ~pclk;
   end

   task automatic give_verdict;
      if (err_count == 0 && total_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      total_checks++;
      if (g !== e) begin
         err_count++;
         $display("ERROR %0t port value %h expected %h", $time, g, e);
      end
   endtask

   // One APB transfer; the idle cycle at the end keeps psel from being driven twice in one step
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   task automatic rd(input logic [11:0] a, input logic [32:0] e);
      exp_q.push_back(e);
      apb(1'b0, a, 32'h0000_0000);
   endtask

   // Two-write divider change, with the reserved bits 6:4 set to show they are dropped
   // Wake sources stay quiet across both writes so nothing can split the pair
   task automatic setdiv(input logic [3:0] c);
      apb(1'b1, clk_ctrl_pkg::CLK_DIV_ADDR, 32'h0000_0080);
      apb(1'b1, clk_ctrl_pkg::CLK_DIV_ADDR, {24'h00_0000, 4'h7, c});
   endtask

   task automatic tick_gap(output int g);
      g = 0;
      do @(posedge pclk); while (sys_tick !== 1'b1);
      do begin
         @(posedge pclk);
         g++;
      end while (sys_tick !== 1'b1 && g < 600);
   endtask

   task automatic do_reset(input logic fuse);
      presetn <= 1'b0;
      cal_byte <= 8'($urandom);
      div8_fuse_default <= fuse;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      repeat (2) @(posedge pclk);
   endtask

   // Read monitor: each completed read is matched against the oldest expectation
   always @(posedge pclk) begin
      if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 && pwrite === 1'b0) begin
         total_checks++;
         exp_v = exp_q.pop_front();
         if ({pslverr, prdata} !== exp_v) begin
            err_count++;
            $display("ERROR %0t read %h expected %h", $time, {pslverr, prdata}, exp_v);
         end
      end
   end

   // Hang guard, far beyond the few thousand cycles the sequence needs
   initial begin
      #100000;
      err_count++;
      $display("ERROR %0t timeout", $time);
      give_verdict();
   end

   // Main sequence
   initial begin
      {presetn, psel, penable, pwrite, sleep_exec, div8_fuse_default} = 6'b00_0000;
      paddr = 12'h000;
      pwdata = 32'h0000_0000;
      cal_byte = 8'h00;
      irq_v = 7'h00;
      r = $urandom(56661);
      do_reset(1'b0);
      rd(clk_ctrl_pkg::OSC_TRIM_ADDR, {25'h000_0000, cal_byte});
      rd(clk_ctrl_pkg::CLK_DIV_ADDR, 33'h0_0000_0000);
      // Trim writes: the range boundary pair, then random values
      for (int i = 0; i < 4; i++) begin
         t = (i < 2) ? 8'h7f + 8'(i) : 8'($urandom);
         // No nonvolatile write is ever in flight here, so any trim value is allowed
         apb(1'b1, clk_ctrl_pkg::OSC_TRIM_ADDR, {24'h00_0000, t});
         chk(32'(trim_range_sel), 32'(t[7]));
         chk(32'(trim_fine), 32'(t[6:0]));
         rd(clk_ctrl_pkg::OSC_TRIM_ADDR, {25'h000_0000, t});
      end
      rd(12'h004, {1'b1, 32'h0000_0000});
      // Unlock with a nonzero bit beside it is dropped, so the select write is too
      apb(1'b1, clk_ctrl_pkg::CLK_DIV_ADDR, 32'h0000_0081);
      apb(1'b1, clk_ctrl_pkg::CLK_DIV_ADDR, 32'h0000_0005);
      rd(clk_ctrl_pkg::CLK_DIV_ADDR, 33'h0_0000_0000);
      // Select write landing one edge past the window, which covers the four edges after the unlock
      apb(1'b1, clk_ctrl_pkg::CLK_DIV_ADDR, 32'h0000_0080);
      repeat (2) @(posedge pclk);
      apb(1'b1, clk_ctrl_pkg::CLK_DIV_ADDR, 32'h0000_0005);
      rd(clk_ctrl_pkg::CLK_DIV_ADDR, 33'h0_0000_0000);
      // A second unlock must not stretch the window
      apb(1'b1, clk_ctrl_pkg::CLK_DIV_ADDR, 32'h0000_0080);
      apb(1'b1, clk_ctrl_pkg::CLK_DIV_ADDR, 32'h0000_0080);
      apb(1'b1, clk_ctrl_pkg::CLK_DIV_ADDR, 32'h0000_0005);
      rd(clk_ctrl_pkg::CLK_DIV_ADDR, 33'h0_0000_0000);
      // Unlock visible, then gone after its window
      apb(1'b1, clk_ctrl_pkg::CLK_DIV_ADDR, 32'h0000_0080);
      rd(clk_ctrl_pkg::CLK_DIV_ADDR, 33'h0_0000_0080);
      rd(clk_ctrl_pkg::CLK_DIV_ADDR, 33'h0_0000_0000);
      // Every legal code; the first gaps after a change are the switch-over and are skipped
      for (int c = 0; c <= 8; c++) begin
         setdiv(4'(c));
         rd(clk_ctrl_pkg::CLK_DIV_ADDR, {29'h0000_0000, 4'(c)});
         tick_gap(n);
         tick_gap(n);
         tick_gap(n);
         chk(32'(n), 32'(1) << c);
      end
      do_reset(1'b1);
      rd(clk_ctrl_pkg::CLK_DIV_ADDR, 33'h0_0000_0003);
      rd(clk_ctrl_pkg::OSC_TRIM_ADDR, {25'h000_0000, cal_byte});
      setdiv(4'h0);
      rd(clk_ctrl_pkg::CLK_DIV_ADDR, 33'h0_0000_0000);
      // Sleep instruction without the arm bit
      apb(1'b1, clk_ctrl_pkg::MCU_CTRL_ADDR, 32'h0000_0000);
      sleep_exec <= 1'b1;
      @(posedge pclk);
      sleep_exec <= 1'b0;
      repeat (3) @(posedge pclk);
      chk(32'(en_v), 32'h0000_001f);
      // Each sleep kind: gating, refused sources, then a wake
      for (int k = 0; k < 4; k++) begin
         apb(1'b1, clk_ctrl_pkg::MCU_CTRL_ADDR, {29'h0000_0000, 1'b1, 2'(k)});
         sleep_exec <= 1'b1;
         @(posedge pclk);
         sleep_exec <= 1'b0;
         repeat (2) @(posedge pclk);
         chk(32'(en_v), 32'(en_tab[k]));
         rd(clk_ctrl_pkg::STATUS_ADDR, {21'h00_0000, en_tab[k], 1'b1, 2'(k), 4'h0});
         irq_v <= no_tab[k];
         repeat (3) @(posedge pclk);
         chk(32'(cpu_clk_en), 32'h0000_0000);
         irq_v <= wake_tab[k];
         // Pulse rises with the enables and stands for the one cycle after leaving sleep
         repeat (2) @(posedge pclk);
         chk(32'(wake_pulse), 32'h0000_0001);
         chk(32'(en_v), 32'h0000_001f);
         irq_v <= 7'h00;
         @(posedge pclk);
         chk(32'(wake_pulse), 32'h0000_0000);
      end
      give_verdict();
   end
endmodule // clk_trim_prescale_sleep_tb
